// ---- core/kwi_keypad_wake.sv ----
/*
 * kwi_keypad_wake: keypad wake interrupt with APB register access.
 * Assumes pins arrive asynchronously, vector fetch strobe and break flag
 * come from logic on ref_clk, and pads resolve pull-up/direction outside.
 */
// The implementer's own choice: register access over APB.
// Overview of operation
// - five keypad pins, each with enable bit, feed one shared request
// - enabled pin gets pull-up and is forced to input
// - request latched when enabled pins go low after all were high
// - edge-only: no new request while another enabled pin is low
// - edge-and-level: clear needs acknowledge and all enabled pins high
// - acknowledge comes from vector fetch or writing 1 to ack bit
// - edge-only: acknowledge clears the request at once
// - falling edge after acknowledge latches a fresh request
// - unmasked pending request drives CPU interrupt, vector FFDE/FFDF
// - reset clears request and selects edge-only
// - pending flag reads 1 when latched, ignores mask, reset clears
// - ack bit write-only, reads 0, writing 1 clears request
// - mask bit 1 blocks interrupt line, reset clears it
// - sensitivity bit 1 edges plus levels, 0 edges only
// - upper four status bits read as zero
// - reset clears all pin enable bits
// - logic runs in wait and stop; unmasked request wakes CPU
// - in break, ack write clears flag only when break clear enable set
// - pin level readable only when its direction bit is 0
`timescale 1ns/1ps
module kwi_keypad_wake #(
   parameter int NUM_PINS = kwi_pkg::KWI_NUM_PINS
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // keypad pins and pad control
   input wire logic [NUM_PINS-1:0] keyPin,
   output logic [NUM_PINS-1:0] pullUpEnable,
   output logic [NUM_PINS-1:0] forceInput,
   // cpu side
   input wire logic vectorFetch,
   input wire logic breakState,
   output logic keypadIrq,
   output logic wakeRequest
);

   // -------------------------------------------------------------
   // bus decode
   // -------------------------------------------------------------
   kwi_pkg::kwi_apb_req_t req;
   kwi_pkg::kwi_apb_rsp_t rsp;
   kwi_pkg::kwi_state_t state_ff;
   kwi_pkg::kwi_state_t nxt_state;
   logic access;
   logic wrLow;
   logic hitStat;
   logic hitEn;
   logic hitBrk;
   logic hitDir;
   logic hitLvl;
   logic mapped;
   logic ackWrite;
   logic ackEvent;
   logic [4:0] enPins;
   logic anyLow;
   logic rdSetup;

   // word-aligned indexes; byte lane 0 carries every register
   function automatic logic hit(input logic [11:0] a, input logic [7:0] i);
      hit = (a == 12'(i * kwi_pkg::KWI_BYTES_PER_WORD));
   endfunction : hit

   assign req = '{sel: psel, enable: penable, write: pwrite,
                  addr: paddr, wdata: pwdata};
   assign access = req.sel & req.enable;
   assign rdSetup = req.sel & ~req.enable & ~req.write;
   assign wrLow = access & req.write & pstrb[0];
   assign hitStat = hit(req.addr, kwi_pkg::KWI_IDX_STATUS_CONTROL);
   assign hitEn = hit(req.addr, kwi_pkg::KWI_IDX_PIN_ENABLE);
   assign hitBrk = hit(req.addr, kwi_pkg::KWI_IDX_BREAK_CONTROL);
   assign hitDir = hit(req.addr, kwi_pkg::KWI_IDX_PORT_DIRECTION);
   assign hitLvl = hit(req.addr, kwi_pkg::KWI_IDX_PIN_LEVEL);
   assign mapped = hitStat | hitEn | hitBrk | hitDir | hitLvl;

   // -------------------------------------------------------------
   // acknowledge and pin view
   // -------------------------------------------------------------
   // a break-time ack write is dropped unless break clear is allowed
   assign ackWrite = wrLow & hitStat & req.wdata[kwi_pkg::KWI_BIT_ACK]
                     & (~breakState | state_ff.breakClr);
   assign ackEvent = ackWrite | vectorFetch;
   assign enPins = state_ff.enable & ~state_ff.pinSync;
   assign anyLow = |enPins;

   // -------------------------------------------------------------
   // next state
   // -------------------------------------------------------------
   always_comb begin
      nxt_state = state_ff;
      // two-stage synchroniser, first stage read by second only
      nxt_state.pinMeta = keyPin;
      nxt_state.pinSync = state_ff.pinMeta;
      // armed only once every enabled pin has been high
      nxt_state.allHigh = ~anyLow;
      // register writes
      if (wrLow && hitStat) begin
         nxt_state.mask = req.wdata[kwi_pkg::KWI_BIT_MASK];
         nxt_state.sense = kwi_pkg::kwi_sense_t'(
            req.wdata[kwi_pkg::KWI_BIT_SENSE]);
      end
      if (wrLow && hitEn) begin
         nxt_state.enable = req.wdata[4:0];
      end
      if (wrLow && hitBrk) begin
         nxt_state.breakClr = req.wdata[kwi_pkg::KWI_BIT_BREAK_CLR];
      end
      if (wrLow && hitDir) begin
         nxt_state.direction = req.wdata[4:0];
      end
      // a level-mode ack is kept until every enabled pin is high again
      if (state_ff.sense == kwi_pkg::KWI_EDGE_ONLY) begin
         nxt_state.ackSeen = 1'b0;
      end else if (ackEvent && anyLow) begin
         nxt_state.ackSeen = 1'b1;
      end
      // clear first so that a same-cycle set wins
      if (ackEvent) begin
         if (state_ff.sense == kwi_pkg::KWI_EDGE_ONLY) begin
            nxt_state.pending = 1'b0;
         end
      end
      // level mode: ack and release may come in either order
      if (state_ff.sense == kwi_pkg::KWI_EDGE_LEVEL
          && (ackEvent || state_ff.ackSeen) && !anyLow) begin
         nxt_state.pending = 1'b0;
         nxt_state.ackSeen = 1'b0;
      end
      // new falling edge after all high; acks never block it
      if (anyLow && state_ff.allHigh) begin
         nxt_state.pending = 1'b1;
         nxt_state.ackSeen = 1'b0;
      end
      // level mode keeps the request alive while a pin is low
      if (state_ff.sense == kwi_pkg::KWI_EDGE_LEVEL && anyLow) begin
         nxt_state.pending = 1'b1;
      end
      // read data
      // captured in setup and held, so the access phase sees a settled word
      if (rdSetup) begin
         nxt_state.rdata = 32'h0000_0000;
         if (hitStat) begin
            // upper nibble and ack read as zero
            nxt_state.rdata[kwi_pkg::KWI_BIT_PENDING] =
               state_ff.pending;
            nxt_state.rdata[kwi_pkg::KWI_BIT_MASK] = state_ff.mask;
            nxt_state.rdata[kwi_pkg::KWI_BIT_SENSE] = state_ff.sense;
         end else if (hitEn) begin
            nxt_state.rdata[4:0] = state_ff.enable;
         end else if (hitBrk) begin
            nxt_state.rdata[kwi_pkg::KWI_BIT_BREAK_CLR] = state_ff.breakClr;
         end else if (hitDir) begin
            nxt_state.rdata[4:0] = state_ff.direction;
         end else if (hitLvl) begin
            // outputs read zero; pin only where direction is input
            nxt_state.rdata[4:0] = state_ff.pinSync
                                   & ~state_ff.direction;
         end
      end
   end

   // -------------------------------------------------------------
   // state register
   // -------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_ff.pinMeta <= kwi_pkg::KWI_PINS_IDLE;
         state_ff.pinSync <= kwi_pkg::KWI_PINS_IDLE;
         state_ff.enable <= kwi_pkg::KWI_ENABLE_RST;
         state_ff.direction <= kwi_pkg::KWI_DIR_RST;
         state_ff.mask <= 1'b0;
         state_ff.sense <= kwi_pkg::KWI_EDGE_ONLY;
         state_ff.breakClr <= 1'b0;
         state_ff.pending <= 1'b0;
         state_ff.allHigh <= 1'b1;
         state_ff.ackSeen <= 1'b0;
         state_ff.rdata <= 32'h0000_0000;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // -------------------------------------------------------------
   // outputs
   // -------------------------------------------------------------
   // zero-wait slave; unmapped addresses answer with an error
   assign rsp = '{ready: 1'b1, slverr: access & ~mapped,
                  rdata: state_ff.rdata};
   assign pready = rsp.ready;
   assign pslverr = rsp.slverr;
   assign prdata = rsp.rdata;
   assign pullUpEnable = state_ff.enable;
   assign forceInput = state_ff.enable;
   // no clock gating here, so this works in wait and stop
   assign keypadIrq = state_ff.pending & ~state_ff.mask;
   assign wakeRequest = keypadIrq;

   // -------------------------------------------------------------
   // checks
   // -------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);

   a_irq_follows_mask: assert property (
      keypadIrq == (state_ff.pending && !state_ff.mask))
      else $error("interrupt does not follow pending and mask");
   a_edge_ack_clears: assert property (
      (ackEvent && state_ff.sense == kwi_pkg::KWI_EDGE_ONLY
       && !(anyLow && state_ff.allHigh)) |=> !state_ff.pending)
      else $error("edge-only acknowledge did not clear request");
   a_level_holds: assert property (
      (state_ff.sense == kwi_pkg::KWI_EDGE_LEVEL && anyLow)
      |=> state_ff.pending)
      else $error("level request dropped while pin low");
   a_fall_latches: assert property (
      (anyLow && state_ff.allHigh) |=> state_ff.pending)
      else $error("falling edge did not latch request");
   a_no_edge_retrig: assert property (
      (!state_ff.pending && !state_ff.allHigh && anyLow
       && state_ff.sense == kwi_pkg::KWI_EDGE_ONLY) |=> !state_ff.pending)
      else $error("request latched while another pin low");
   a_break_protect: assert property (
      (breakState && !state_ff.breakClr && !vectorFetch && state_ff.pending)
      |=> state_ff.pending)
      else $error("break write cleared protected flag");
   a_ack_reads_zero: assert property (
      (access && !req.write && hitStat) |-> prdata[7:4] == 4'h0
      && !prdata[kwi_pkg::KWI_BIT_ACK])
      else $error("status upper bits or ack read nonzero");
   a_pin_synced: assert property (
      ($past(reset_n) && $past(reset_n, 2))
      |-> state_ff.pinSync == $past(keyPin, 2))
      else $error("pin synchroniser depth wrong");
   a_pull_enable: assert property (
      pullUpEnable == state_ff.enable && forceInput == state_ff.enable)
      else $error("pull-up not tied to enable");
   a_wake_irq: assert property (
      wakeRequest == keypadIrq)
      else $error("wake does not follow interrupt");

   // -------------------------------------------------------------
   // checks: level acknowledge and register fields
   // -------------------------------------------------------------
   // release after a remembered ack must drop the request
   a_level_ack_clear: assert property (
      (state_ff.sense == kwi_pkg::KWI_EDGE_LEVEL
       && (ackEvent || state_ff.ackSeen) && !anyLow) |=> !state_ff.pending)
      else $error("level request kept after ack and release");
   // an ack while a pin is low must not be lost
   a_ack_remembered: assert property (
      (state_ff.sense == kwi_pkg::KWI_EDGE_LEVEL && ackEvent && anyLow
       && !state_ff.allHigh) |=> state_ff.ackSeen)
      else $error("level acknowledge not remembered");
   // with no enabled pin low nothing may raise the request
   a_no_stray_set: assert property (
      (!state_ff.pending && !anyLow) |=> !state_ff.pending)
      else $error("request set with all enabled pins high");
   // break clear allowed: an edge-only ack must still work
   a_break_clear_ok: assert property (
      (breakState && state_ff.breakClr && ackWrite
       && state_ff.sense == kwi_pkg::KWI_EDGE_ONLY
       && !(anyLow && state_ff.allHigh)) |=> !state_ff.pending)
      else $error("allowed break acknowledge did not clear");
   // pending flag reads back whatever was latched at setup
   a_pend_reads: assert property (
      (rdSetup && hitStat)
      |=> prdata[kwi_pkg::KWI_BIT_PENDING] == $past(state_ff.pending))
      else $error("pending flag read wrong");
   // sensitivity bit reads back as held
   a_sense_reads: assert property (
      (rdSetup && hitStat)
      |=> prdata[kwi_pkg::KWI_BIT_SENSE] == $past(state_ff.sense))
      else $error("sensitivity bit read wrong");
   // only the low byte of any register may be nonzero
   a_upper_zero: assert property (
      rdSetup |=> prdata[31:8] == 24'h00_0000)
      else $error("read data above low byte nonzero");
   // enable bits read back as held
   a_en_reads: assert property (
      (rdSetup && hitEn) |=> prdata[4:0] == $past(state_ff.enable))
      else $error("enable bits read wrong");
   // pin level read masks pins driven as outputs
   a_lvl_reads: assert property (
      (rdSetup && hitLvl) |=> prdata[4:0] ==
      ($past(state_ff.pinSync) & ~$past(state_ff.direction)))
      else $error("pin level read wrong");
   // mask bit takes the written value
   a_mask_write: assert property (
      (wrLow && hitStat)
      |=> state_ff.mask == $past(req.wdata[kwi_pkg::KWI_BIT_MASK]))
      else $error("mask write lost");
   // sensitivity bit takes the written value
   a_sense_write: assert property (
      (wrLow && hitStat)
      |=> state_ff.sense == $past(req.wdata[kwi_pkg::KWI_BIT_SENSE]))
      else $error("sensitivity write lost");
   // enable bits take the written value
   a_enable_write: assert property (
      (wrLow && hitEn) |=> state_ff.enable == $past(req.wdata[4:0]))
      else $error("enable write lost");
   // direction bits take the written value
   a_dir_write: assert property (
      (wrLow && hitDir) |=> state_ff.direction == $past(req.wdata[4:0]))
      else $error("direction write lost");
   // break clear bit takes the written value
   a_bclr_write: assert property (
      (wrLow && hitBrk) |=> state_ff.breakClr
      == $past(req.wdata[kwi_pkg::KWI_BIT_BREAK_CLR]))
      else $error("break clear write lost");

   // -------------------------------------------------------------
   // covers
   // -------------------------------------------------------------

   c_edge_irq: cover property (
      state_ff.sense == kwi_pkg::KWI_EDGE_ONLY && $rose(keypadIrq));
   c_level_ack_wait: cover property (
      state_ff.sense == kwi_pkg::KWI_EDGE_LEVEL && ackEvent && anyLow);
   c_break_ack: cover property (breakState && ackWrite);
   c_vector_clear: cover property (vectorFetch ##1 !state_ff.pending);
   c_level_release: cover property (
      state_ff.sense == kwi_pkg::KWI_EDGE_LEVEL && state_ff.ackSeen && !anyLow);
endmodule : kwi_keypad_wake

// ---- inc/kwi_pkg.sv ----
/*
 * kwi_pkg: constants and carrier types for the keypad wake interrupt block.
 * Assumes a 32-bit APB register bus and a 40 MHz bus clock.
 */
package kwi_pkg;
   // -------------------------------------------------------------
   // register map
   // -------------------------------------------------------------
   // printed offsets are not word multiples, so they are indexes
   localparam logic [7:0] KWI_IDX_STATUS_CONTROL = 8'h1a;
   localparam logic [7:0] KWI_IDX_PIN_ENABLE = 8'h1b;
   localparam logic [7:0] KWI_IDX_BREAK_CONTROL = 8'h1c;
   localparam logic [7:0] KWI_IDX_PORT_DIRECTION = 8'h1d;
   localparam logic [7:0] KWI_IDX_PIN_LEVEL = 8'h1e;
   localparam int KWI_BYTES_PER_WORD = 4;
   localparam int KWI_ADDR_W = 12;

   // -------------------------------------------------------------
   // status/control and break control field positions
   // -------------------------------------------------------------
   localparam int KWI_BIT_PENDING = 3;
   localparam int KWI_BIT_ACK = 2;
   localparam int KWI_BIT_MASK = 1;
   localparam int KWI_BIT_SENSE = 0;
   localparam int KWI_BIT_BREAK_CLR = 0;

   // -------------------------------------------------------------
   // geometry and reset values
   // -------------------------------------------------------------
   localparam int KWI_NUM_PINS = 5;
   localparam logic [4:0] KWI_ENABLE_RST = 5'h00;
   localparam logic [4:0] KWI_DIR_RST = 5'h00;
   localparam logic [4:0] KWI_PINS_IDLE = 5'h1f;

   // sensitivity selection
   typedef enum logic [0:0] {
      KWI_EDGE_ONLY = 1'b0,
      KWI_EDGE_LEVEL = 1'b1
   } kwi_sense_t;

   // apb request carrier
   typedef struct packed {
      logic sel;
      logic enable;
      logic write;
      logic [KWI_ADDR_W-1:0] addr;
      logic [31:0] wdata;
   } kwi_apb_req_t;

   // apb answer carrier
   typedef struct packed {
      logic ready;
      logic slverr;
      logic [31:0] rdata;
   } kwi_apb_rsp_t;

   // whole state of the block
   typedef struct packed {
      logic [4:0] pinMeta;
      logic [4:0] pinSync;
      logic [4:0] enable;
      logic [4:0] direction;
      logic mask;
      kwi_sense_t sense;
      logic breakClr;
      logic pending;
      logic allHigh;
      logic ackSeen;
      logic [31:0] rdata;
   } kwi_state_t;
endpackage : kwi_pkg

// ---- verif/kwi_keypad_switches.sv ----
/*
 * kwi_keypad_switches: keypad switches on the five keypad pins.
 * Assumes the pads pull a pin up only while the block asks for it.
 */
`timescale 1ns/1ps
module kwi_keypad_switches (
   // clock
   input wire logic ref_clk,
   // key presses and pad pull-ups
   input wire logic [4:0] pressed,
   input wire logic [4:0] pullUpEnable,
   // pins
   output logic [4:0] keyPin
);
   logic [4:0] floatVal = 5'h00;

   // a free pin toggles, so a stale level never passes for a valid one
   always @(posedge ref_clk) begin
      floatVal <= ~floatVal;
   end

   // a pressed key pulls low, else the pull-up or the floating pattern
   assign keyPin = ~pressed & (pullUpEnable | floatVal);
endmodule : kwi_keypad_switches

// ---- verif/tb_top.sv ----
/*
 * tb_top: self-checking bench of the keypad wake block over APB.
 * Assumes zero-wait APB answers and a 3-edge pin-to-flag latency.
 */
`timescale 1ns/1ps
module tb_top;
   localparam logic [7:0] ST = kwi_pkg::KWI_IDX_STATUS_CONTROL;
   localparam logic [7:0] EN = kwi_pkg::KWI_IDX_PIN_ENABLE;
   logic ref_clk, reset_n, psel, penable, pwrite, vectorFetch, breakState;
   logic pready, pslverr, keypadIrq, wakeRequest, errv;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdv, rnd;
   logic [4:0] keyPin, pullUpEnable, forceInput, keys, mEn;
   logic mPend, mMask, mSense, mBclr, mAck;
   int fail_count = 0;
   int checked = 0;

   kwi_keypad_wake i_dut (.ref_clk, .reset_n, .psel, .penable, .pwrite,
      .paddr, .pstrb(4'hf), .pwdata, .prdata, .pready, .pslverr, .keyPin,
      .pullUpEnable, .forceInput, .vectorFetch, .breakState, .keypadIrq,
      .wakeRequest);
   kwi_keypad_switches i_keys (.ref_clk, .pressed(keys), .pullUpEnable,
      .keyPin);

   // 40 MHz bus clock
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end

   // ----------------------------------------------------------
   // helpers
   // ----------------------------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction : xs

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk

   // one apb transfer; always enters and leaves just after a rising edge
   task automatic apb(input logic w, input logic [7:0] idx,
      input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {2'h0, idx, 2'h0};
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rdv = prdata;
      errv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 50) begin
         fail_count++;
      end
      @(posedge ref_clk);
   endtask : apb

   // acknowledge as the model sees it: break guard, then level guard
   // a level ack with a pin low is remembered until all are high
   function automatic void ackModel();
      if (!(breakState && !mBclr)) begin
         if (mSense && (mEn & keys) != 5'h00) begin
            mAck = 1'b1;
         end else begin
            mPend = 1'b0;
         end
      end
   endfunction : ackModel

   task automatic ws(input logic [31:0] v);
      apb(1'b1, ST, v);
      if (v[2]) begin
         ackModel();
      end
      mMask = v[1];
      mSense = v[0];
      mAck = mAck & v[0];
   endtask : ws

   task automatic cs();
      apb(1'b0, ST, 32'h0);
      chk(rdv, {28'h0, mPend, 1'b0, mMask, mSense});
      chk({31'h0, keypadIrq}, {31'h0, mPend & ~mMask});
      chk({31'h0, wakeRequest}, {31'h0, mPend & ~mMask});
   endtask : cs

   // new key state; latency of synchroniser plus flag is three edges
   task automatic press(input logic [4:0] m);
      if ((mEn & m & ~keys) != 5'h00 && (mEn & keys) == 5'h00) begin
         mPend = 1'b1;
         mAck = 1'b0;
      end
      if (mSense && (mEn & m) != 5'h00) begin
         mPend = 1'b1;
      end
      if (mSense && mAck && (mEn & m) == 5'h00) begin
         mPend = 1'b0;
         mAck = 1'b0;
      end
      keys <= m;
      repeat (4) @(posedge ref_clk);
   endtask : press

   task automatic end_sim();
      $display("checked %0d fail_count %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : end_sim

   // watchdog well beyond the few hundred cycles of the sequence
   initial begin
      #(25 * 4000);
      fail_count++;
      end_sim();
   end

   // ----------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------
   initial begin
      reset_n = 1'b0;
      {psel, penable, pwrite, vectorFetch, breakState} = 5'h00;
      paddr = 12'h000;
      pwdata = 32'h0;
      {mPend, mMask, mSense, mBclr, mAck} = 5'h00;
      mEn = 5'h00;
      keys = 5'h00;
      rnd = 32'h909c;
      repeat (20) @(posedge ref_clk);
      reset_n <= 1'b1;
      @(posedge ref_clk);
      cs();
      apb(1'b0, EN, 32'h0);
      chk(rdv, 32'h0);
      ws(32'h02);
      repeat (3) begin
         rnd = xs(rnd);
         apb(1'b1, EN, rnd);
         apb(1'b0, EN, 32'h0);
         chk(rdv, {27'h0, rnd[4:0]});
      end
      apb(1'b1, EN, 32'h1f);
      mEn = 5'h1f;
      repeat (4) @(posedge ref_clk);
      chk({27'h0, pullUpEnable & forceInput}, 32'h1f);
      ws(32'h06);
      ws(32'h00);
      press(5'h01);
      cs();
      ws(32'h04);
      cs();
      press(5'h03);
      cs();
      press(5'h00);
      press(5'h04);
      cs();
      vectorFetch <= 1'b1;
      @(posedge ref_clk);
      vectorFetch <= 1'b0;
      ackModel();
      @(posedge ref_clk);
      cs();
      press(5'h00);
      ws(32'h02);
      press(5'h10);
      cs();
      ws(32'h00);
      cs();
      ws(32'h04);
      press(5'h00);
      ws(32'h01);
      press(5'h08);
      ws(32'h05);
      cs();
      press(5'h00);
      cs();
      ws(32'h05);
      cs();
      ws(32'h00);
      press(5'h02);
      breakState <= 1'b1;
      @(posedge ref_clk);
      ws(32'h04);
      cs();
      apb(1'b1, kwi_pkg::KWI_IDX_BREAK_CONTROL, 32'h1);
      mBclr = 1'b1;
      ws(32'h04);
      breakState <= 1'b0;
      @(posedge ref_clk);
      cs();
      press(5'h00);
      ws(32'hffffffff);
      cs();
      ws(32'h00);
      apb(1'b1, 8'h20, 32'h1);
      chk({31'h0, errv}, 32'h1);
      apb(1'b0, 8'h20, 32'h0);
      chk(rdv, 32'h0);
      apb(1'b1, kwi_pkg::KWI_IDX_PORT_DIRECTION, 32'h01);
      press(5'h06);
      apb(1'b0, kwi_pkg::KWI_IDX_PIN_LEVEL, 32'h0);
      chk(rdv, 32'h18);
      ws(32'h01);
      reset_n <= 1'b0;
      repeat (3) @(posedge ref_clk);
      reset_n <= 1'b1;
      {mPend, mMask, mSense, mBclr, mAck} = 5'h00;
      mEn = 5'h00;
      @(posedge ref_clk);
      cs();
      apb(1'b0, EN, 32'h0);
      chk(rdv, 32'h0);
      chk({27'h0, pullUpEnable}, 32'h0);
      end_sim();
   end
endmodule : tb_top
